// File: core/pcb_pkg.sv
package pcb_pkg;

    // Cache geometry: 32K bytes of 256-bit lines, direct-mapped
    localparam int          LINE_BITS    = 256;
    localparam int          LINE_COUNT   = 1024;
    localparam int          IDX_W        = 10;
    localparam int          TAG_W        = 17;
    localparam int          IDX_LSB      = 5;
    localparam int          TAG_LSB      = 15;
    localparam int          LADDR_W      = 27;
    localparam int          INSTR_PER_LINE = 8;

    // Cache mode field codes
    localparam logic [2:0]  MODE_RESET   = 3'h0;
    localparam logic [2:0]  MODE_ENABLE  = 3'h2;
    localparam logic [2:0]  MODE_FREEZE  = 3'h3;
    localparam logic [2:0]  MODE_BYPASS  = 3'h4;

    // Internal memory pages
    localparam logic [31:0] ROM0_LAST    = 32'h0003_ffff;
    localparam logic [31:0] ROM1_BASE    = 32'h0004_0000;
    localparam logic [31:0] ROM1_LAST    = 32'h0005_ffff;
    localparam logic [31:0] RAM_BASE     = 32'h1000_0000;
    localparam logic [31:0] RAM_LAST     = 32'h1003_ffff;
    localparam int          NUM_BANKS    = 16;
    localparam logic [3:0]  ROM_PAGE_ALL = 4'hf;
    localparam logic [7:0]  RAM_PAGE_ALL = 8'hff;

    // Invalidate control word offsets in the cache control region
    localparam logic [31:0] INV_START_OFS = 32'h0;
    localparam logic [31:0] INV_CTRL_OFS  = 32'h4;

    // Fill timing, in core cycles beyond a hit
    localparam int          MISS_PENALTY = 2;

    typedef enum logic [2:0] {
        S_IDLE,
        S_FILL,
        S_LOAD,
        S_EXT,
        S_INV
    } pcb_state_t;

endpackage

// File: core/pcb_bank_decode.sv
module pcb_bank_decode (
    input  wire logic [31:0] addr,      // Access byte address
    input  wire logic        wide,      // 64-bit data access
    input  wire logic        wholePage, // Line fill claims the whole page
    output logic [15:0]      bankMask,  // Banks claimed this cycle
    output logic             internal   // Address falls in internal ROM or RAM
);
    logic       isRom0;
    logic       isRom1;
    logic       isRam;
    logic [3:0] romBanks;
    logic [7:0] ramBanks;

    assign isRom0   = addr <= pcb_pkg::ROM0_LAST;
    assign isRom1   = addr >= pcb_pkg::ROM1_BASE && addr <= pcb_pkg::ROM1_LAST;
    assign isRam    = addr >= pcb_pkg::RAM_BASE && addr <= pcb_pkg::RAM_LAST;
    // ROM banks are 64 bits wide, RAM banks 32; a wide RAM access takes a bank pair
    assign romBanks = wholePage ? pcb_pkg::ROM_PAGE_ALL : (4'h1 << addr[4:3]);
    assign ramBanks = wholePage ? pcb_pkg::RAM_PAGE_ALL :
                      wide ? (8'h3 << {addr[4:3], 1'b0}) : (8'h1 << addr[4:2]);
    assign bankMask = {isRam ? ramBanks : 8'h0, isRom1 ? romBanks : 4'h0, isRom0 ? romBanks : 4'h0};
    assign internal = isRom0 | isRom1 | isRam;
endmodule

// File: core/pcb_cache.sv
// Behaviour
// - A 32K-byte direct-mapped program cache feeds every instruction fetch.
// - A hit returns the fetch line one cycle after the request is taken.
// - Lines are 256 bits and an internal miss fills the whole line with a 2-cycle penalty.
// - One line carries eight 32-bit instructions, a full fetch packet.
// - Code from external memory is cached too, with misses served over the external path.
// - Software picks one of three modes: enable, freeze or bypass.
// - Software starts an invalidate over an address range after changing program memory.
// - Internal ROM is two 256-bit pages of four 64-bit banks each.
// - Internal RAM is one 256-bit page of eight 32-bit banks.
// - Two 64-bit core accesses, one line fill and one 32-bit peripheral access are taken each cycle.
// - A line fill collides only with data accesses to its own page.
// - Data accesses to different pages or different banks all proceed together.
// - Mode code 010b fills on misses, 011b freezes contents, 100b bypasses the cache.
// - The reset mode code 000b behaves as enable.
// - Invalidation is driven by a start address and an invalidate control word at offsets 0x0 and 0x4.
module pcb_cache (
    input  wire logic         clk,            // Core clock
    input  wire logic         rst,            // Synchronous reset, active high
    input  wire logic [2:0]   cacheModeField, // Mode field of the core control status register
    input  wire logic         fetchReq,       // Fetch request, held until taken
    input  wire logic [31:0]  fetchAddr,      // Fetch byte address
    output logic              fetchReady,     // Fetch request taken this cycle
    output logic              fetchValid,     // Fetch packet valid, one-cycle pulse
    output logic [255:0]      fetchData,      // Fetch packet of eight instructions
    input  wire logic         invStart,       // Invalidate control write, pulse
    input  wire logic [31:0]  invStartAddr,   // Invalidate start address
    input  wire logic [15:0]  invWordCount,   // Invalidate length in 32-bit words
    output logic              invBusy,        // Invalidate in progress
    output logic              memFillEn,      // Line read to internal memory
    output logic [31:0]       memFillAddr,    // Line-aligned fill address
    input  wire logic [255:0] memLineData,    // Line data, one cycle after memFillEn
    output logic              extReq,         // Line read on the external path
    output logic [31:0]       extAddr,        // Line-aligned external address
    input  wire logic         extValid,       // External line data valid
    input  wire logic [255:0] extData,        // External line data
    input  wire logic         coreAReq,       // Core data access A, 64-bit
    input  wire logic [31:0]  coreAAddr,      // Core data access A address
    output logic              coreAGrant,     // Access A proceeds this cycle
    input  wire logic         coreBReq,       // Core data access B, 64-bit
    input  wire logic [31:0]  coreBAddr,      // Core data access B address
    output logic              coreBGrant,     // Access B proceeds this cycle
    input  wire logic         perReq,         // Peripheral 32-bit access
    input  wire logic [31:0]  perAddr,        // Peripheral access address
    output logic              perGrant        // Peripheral access proceeds this cycle
);
    localparam int IW = pcb_pkg::IDX_W;
    localparam int TW = pcb_pkg::TAG_W;

    pcb_pkg::pcb_state_t st_q;

    logic [pcb_pkg::LINE_BITS-1:0] line_q [pcb_pkg::LINE_COUNT];
    logic [TW-1:0]                 tag_q  [pcb_pkg::LINE_COUNT];
    logic [pcb_pkg::LINE_COUNT-1:0] validQ_q;
    logic [31:0]                   missAddr_q;
    logic [pcb_pkg::LADDR_W-1:0]   invCur_q;
    logic [pcb_pkg::LADDR_W-1:0]   invEnd_q;
    logic                          fetchValid_q;
    logic [255:0]                  fetchData_q;

    wire [IW-1:0] fetchIdx  = fetchAddr[pcb_pkg::TAG_LSB-1:pcb_pkg::IDX_LSB];
    wire [TW-1:0] fetchTag  = fetchAddr[31:pcb_pkg::TAG_LSB];
    wire [IW-1:0] missIdx   = missAddr_q[pcb_pkg::TAG_LSB-1:pcb_pkg::IDX_LSB];
    wire [TW-1:0] missTag   = missAddr_q[31:pcb_pkg::TAG_LSB];
    wire [IW-1:0] invIdx    = invCur_q[IW-1:0];
    wire [TW-1:0] invTag    = invCur_q[pcb_pkg::LADDR_W-1:IW];
    wire [31:0]   invLast   = invStartAddr + {14'h0, invWordCount, 2'b00} - 32'h1;

    // Reserved codes fall back to enable so the core keeps running
    wire modeFreeze = cacheModeField == pcb_pkg::MODE_FREEZE;
    wire modeBypass = cacheModeField == pcb_pkg::MODE_BYPASS;
    wire modeAlloc  = !modeFreeze && !modeBypass;

    wire hitNow     = validQ_q[fetchIdx] && tag_q[fetchIdx] == fetchTag && !modeBypass;
    wire fetchTake  = fetchReq && fetchReady;
    wire invMatch   = validQ_q[invIdx] && tag_q[invIdx] == invTag;
    wire lineArrive = st_q == pcb_pkg::S_LOAD || (st_q == pcb_pkg::S_EXT && extValid);
    wire lineWrite  = lineArrive && modeAlloc;
    wire [255:0] lineIn = st_q == pcb_pkg::S_LOAD ? memLineData : extData;

    logic [15:0] fillMask;
    logic [15:0] aMask;
    logic [15:0] bMask;
    logic [15:0] pMask;
    logic        fetchInternal;
    logic        missInternal;

    pcb_bank_decode uFetchDec (.addr(fetchAddr), .wide(1'b1), .wholePage(1'b1),
                               .bankMask(), .internal(fetchInternal));
    pcb_bank_decode uFillDec  (.addr(missAddr_q), .wide(1'b1), .wholePage(1'b1),
                               .bankMask(fillMask), .internal(missInternal));
    pcb_bank_decode uADec     (.addr(coreAAddr), .wide(1'b1), .wholePage(1'b0),
                               .bankMask(aMask), .internal());
    pcb_bank_decode uBDec     (.addr(coreBAddr), .wide(1'b1), .wholePage(1'b0),
                               .bankMask(bMask), .internal());
    pcb_bank_decode uPDec     (.addr(perAddr), .wide(1'b0), .wholePage(1'b0),
                               .bankMask(pMask), .internal());

    // Fill wins its page for its one cycle; data then A, B, peripheral by bank
    wire [15:0] fillUse = memFillEn ? fillMask : 16'h0;
    wire [15:0] aUse    = fillUse | (coreAGrant ? aMask : 16'h0);
    wire [15:0] bUse    = aUse | (coreBGrant ? bMask : 16'h0);

    assign memFillEn   = st_q == pcb_pkg::S_FILL;
    assign memFillAddr = {missAddr_q[31:pcb_pkg::IDX_LSB], 5'h0};
    assign coreAGrant  = coreAReq && (aMask & fillUse) == 16'h0;
    assign coreBGrant  = coreBReq && (bMask & aUse) == 16'h0;
    assign perGrant    = perReq && (pMask & bUse) == 16'h0;
    assign extReq      = st_q == pcb_pkg::S_EXT;
    assign extAddr     = memFillAddr;
    assign invBusy     = st_q == pcb_pkg::S_INV;
    assign fetchReady  = st_q == pcb_pkg::S_IDLE && !invStart;
    assign fetchValid  = fetchValid_q;
    assign fetchData   = fetchData_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= pcb_pkg::S_IDLE;
        end else begin
            unique case (st_q)
                pcb_pkg::S_IDLE: begin
                    if (invStart && invWordCount != 16'h0) begin
                        st_q <= pcb_pkg::S_INV;
                    end else if (fetchTake && !hitNow) begin
                        st_q <= fetchInternal ? pcb_pkg::S_FILL : pcb_pkg::S_EXT;
                    end
                end
                pcb_pkg::S_FILL: st_q <= pcb_pkg::S_LOAD;
                pcb_pkg::S_LOAD: st_q <= pcb_pkg::S_IDLE;
                pcb_pkg::S_EXT: begin
                    if (extValid) begin
                        st_q <= pcb_pkg::S_IDLE;
                    end
                end
                pcb_pkg::S_INV: begin
                    if (invCur_q == invEnd_q) begin
                        st_q <= pcb_pkg::S_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fetchValid_q <= 1'b0;
            fetchData_q  <= 256'h0;
            missAddr_q   <= 32'h0;
            invCur_q     <= '0;
            invEnd_q     <= '0;
        end else begin
            fetchValid_q <= (fetchTake && hitNow) || lineArrive;
            if (fetchTake && hitNow) begin
                fetchData_q <= line_q[fetchIdx];
            end else if (lineArrive) begin
                fetchData_q <= lineIn;
            end
            if (fetchTake) begin
                missAddr_q <= fetchAddr;
            end
            if (st_q == pcb_pkg::S_IDLE && invStart) begin
                invCur_q <= invStartAddr[31:pcb_pkg::IDX_LSB];
                invEnd_q <= invLast[31:pcb_pkg::IDX_LSB];
            end else if (invBusy) begin
                invCur_q <= invCur_q + 27'h1;
            end
        end
    end

    // Valid bits: allocation and invalidation never share a state
    always_ff @(posedge clk) begin
        if (rst) begin
            validQ_q <= '0;
        end else if (lineWrite) begin
            validQ_q[missIdx] <= 1'b1;
        end else if (invBusy && invMatch) begin
            validQ_q[invIdx] <= 1'b0;
        end
    end

    // Line and tag storage need no reset; validQ_q guards them
    always_ff @(posedge clk) begin
        if (lineWrite) begin
            line_q[missIdx] <= lineIn;
            tag_q[missIdx]  <= missTag;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    hit_latency_a: assert property (
        fetchTake && hitNow |=> fetchValid && fetchData == $past(line_q[fetchIdx]))
        else $error("hit not returned in one cycle");
    miss_penalty_a: assert property (
        fetchTake && !hitNow && fetchInternal && !invStart
        |=> memFillEn && !fetchValid ##1 !fetchValid ##1 fetchValid)
        else $error("internal miss penalty is not two cycles");
    ext_path_a: assert property (
        fetchTake && !hitNow && !fetchInternal |=> extReq && !memFillEn [*1] ##0 !fetchValid)
        else $error("external miss not sent on external path");
    fill_page_a: assert property (
        memFillEn |-> !(coreAGrant && (aMask & fillMask) != 16'h0)
                   && !(coreBGrant && (bMask & fillMask) != 16'h0)
                   && !(perGrant && (pMask & fillMask) != 16'h0))
        else $error("fill shares its page with a data access");
    bank_excl_a: assert property (
        coreAGrant && coreBGrant |-> (aMask & bMask) == 16'h0)
        else $error("two core accesses granted on one bank");
    stall_cause_a: assert property (
        coreAReq && !coreAGrant |-> memFillEn && (aMask & fillMask) != 16'h0)
        else $error("core access A stalled without a collision");
    bypass_miss_a: assert property (
        fetchTake && modeBypass && fetchInternal |=> !fetchValid ##1 !fetchValid)
        else $error("bypass mode returned a hit");
    freeze_keep_a: assert property (
        st_q == pcb_pkg::S_LOAD && modeFreeze |=> validQ_q == $past(validQ_q))
        else $error("freeze mode changed the cache contents");
    reset_mode_a: assert property (
        st_q == pcb_pkg::S_LOAD && cacheModeField == pcb_pkg::MODE_RESET |=> validQ_q[$past(missIdx)])
        else $error("reset mode code did not allocate on miss");
    inv_clear_a: assert property (
        invBusy |=> !validQ_q[$past(invIdx)] || !$past(invMatch))
        else $error("invalidate left a matching line valid");
    inv_end_a: assert property (
        invBusy && invCur_q == invEnd_q |=> st_q == pcb_pkg::S_IDLE && !fetchValid)
        else $error("invalidate did not end at its last line");
endmodule

// File: testbench/pcb_mem_model.sv
module pcb_mem_model (
    input  wire logic         clk,         // Core clock
    input  wire logic         rst,         // Synchronous reset
    input  wire logic         memFillEn,   // Internal line read
    input  wire logic [31:0]  memFillAddr, // Internal line address
    output logic [255:0]      memLineData, // Internal line, cycle after the read
    input  wire logic         extReq,      // External line request
    input  wire logic [31:0]  extAddr,     // External line address
    output logic              extValid,    // External data pulse
    output logic [255:0]      extData,     // External line data
    input  wire logic [3:0]   extDelay     // Wait cycles before answering
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt_q;

    function automatic logic [255:0] line_of(input logic [31:0] a);
        for (int k = 0; k < 8; k++)
            line_of[32*k +: 32] = {a[31:5], k[2:0], 2'h1};
    endfunction

    // Stale data is scrambled every cycle so a late or early sample shows up
    always_ff @(posedge clk) begin
        memLineData <= rst ? '0 : (memFillEn ? line_of(memFillAddr) : ~memLineData);
        if (rst || !extReq || extValid) begin
            waitCnt_q <= 4'h0;
            extValid <= 1'b0;
            extData  <= rst ? '0 : ~extData;
        end else if (waitCnt_q == extDelay) begin
            extValid <= 1'b1;
            extData  <= ~line_of(extAddr);
        end else begin
            waitCnt_q <= waitCnt_q + 4'h1;
            extData <= ~extData;
        end
    end
endmodule

// File: testbench/pcb_cache_tb.sv
module pcb_cache_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk, rst, fetchReq, fetchReady, fetchValid, invStart, invBusy, memFillEn, extReq, extValid;
    logic         coreAReq, coreBReq, perReq, coreAGrant, coreBGrant, perGrant;
    logic [2:0]   cacheModeField;
    logic [3:0]   extDelay;
    logic [15:0]  invWordCount;
    logic [31:0]  fetchAddr, invStartAddr, memFillAddr, extAddr, coreAAddr, coreBAddr, perAddr, a, l0;
    logic [255:0] fetchData, memLineData, extData;
    int           err_total = 0;
    int           samples_checked = 0;
    // Internal miss answers one hit cycle plus the fill penalty
    localparam int missLat = 1 + pcb_pkg::MISS_PENALTY;
    logic [2:0]   modes [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h7};

    pcb_cache u_pcb_cache (.clk(clk), .rst(rst), .cacheModeField(cacheModeField), .fetchReq(fetchReq),
        .fetchAddr(fetchAddr), .fetchReady(fetchReady), .fetchValid(fetchValid), .fetchData(fetchData),
        .invStart(invStart), .invStartAddr(invStartAddr), .invWordCount(invWordCount), .invBusy(invBusy),
        .memFillEn(memFillEn), .memFillAddr(memFillAddr), .memLineData(memLineData), .extReq(extReq),
        .extAddr(extAddr), .extValid(extValid), .extData(extData), .coreAReq(coreAReq), .coreAAddr(coreAAddr),
        .coreAGrant(coreAGrant), .coreBReq(coreBReq), .coreBAddr(coreBAddr), .coreBGrant(coreBGrant),
        .perReq(perReq), .perAddr(perAddr), .perGrant(perGrant));
    pcb_mem_model u_pcb_mem_model (.clk(clk), .rst(rst), .memFillEn(memFillEn), .memFillAddr(memFillAddr),
        .memLineData(memLineData), .extReq(extReq), .extAddr(extAddr), .extValid(extValid),
        .extData(extData), .extDelay(extDelay));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    function automatic logic [15:0] banks(input logic [31:0] x, input logic wide);
        if (x <= pcb_pkg::ROM0_LAST) return 16'h0001 << x[4:3];
        if (x >= pcb_pkg::ROM1_BASE && x <= pcb_pkg::ROM1_LAST) return 16'h0010 << x[4:3];
        if (x >= pcb_pkg::RAM_BASE && x <= pcb_pkg::RAM_LAST) begin
            return wide ? 16'h0300 << {x[4:3], 1'b0} : 16'h0100 << x[4:2];
        end
        return 16'h0000;
    endfunction

    function automatic logic [15:0] page_of(input logic [31:0] x);
        logic [15:0] m;
        m = banks(x, 1'b1);
        return (m[3:0] != 4'h0) ? 16'h000f : (m[7:4] != 4'h0) ? 16'h00f0 : (m != 16'h0) ? 16'hff00 : 16'h0;
    endfunction

    function automatic logic [31:0] pick();
        case ($urandom % 4)
            0: return $urandom & 32'h0003_ffff;
            1: return pcb_pkg::ROM1_BASE | ($urandom & 32'h0001_ffff);
            2: return pcb_pkg::RAM_BASE | ($urandom & 32'h0003_ffff);
            default: return 32'h8000_0000 | $urandom;
        endcase
    endfunction

    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH at %0t: %s", $time, msg);
        end
    endtask

    task automatic fetch(input logic [31:0] x, input int lat);
        logic [255:0] exp;
        int n;
        for (int k = 0; k < 8; k++)
            exp[32*k +: 32] = {x[31:5], k[2:0], 2'h1};
        if (banks(x, 1'b1) == 16'h0) exp = ~exp;
        @(posedge clk);
        fetchReq  <= 1'b1;
        fetchAddr <= x;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fetchReady !== 1'b1 && n < 50);
        @(posedge clk);
        fetchReq <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fetchValid !== 1'b1 && n < 50);
        if (lat > 0) check(n == lat, "fetch latency");
        check(fetchData === exp, "fetch packet");
    endtask

    task automatic inval(input logic [31:0] x, input logic [15:0] cnt);
        int n;
        int expL;
        expL = (cnt == 16'h0) ? 0 : int'(((x + ({16'h0, cnt} << 2) - 32'h1) >> 5) - (x >> 5)) + 1;
        @(posedge clk);
        invStart     <= 1'b1;
        invStartAddr <= x;
        invWordCount <= cnt;
        @(posedge clk);
        invStart <= 1'b0;
        n = 0;
        forever begin
            @(negedge clk);
            if (invBusy !== 1'b1 || n > 300) break;
            n++;
        end
        check(n == expL, "invalidate walk length");
    endtask

    // Requests stay up until granted; a parallel line fill can land on their page
    task automatic arb_trial(input logic [31:0] x, input logic withFill);
        logic [15:0] fm, ma, mb, mp;
        logic ea, eb, ep, pa, pb, pp;
        if (withFill) begin
            fork
                fetch(x ^ 32'h2000, -1);
            join_none
        end
        repeat (withFill ? 2 : 1) @(posedge clk);
        {pa, pb, pp} = 3'b111;
        coreAReq  <= 1'b1;
        coreBReq  <= 1'b1;
        perReq    <= 1'b1;
        coreAAddr <= x;
        coreBAddr <= pick();
        perAddr   <= pick();
        for (int n = 0; n < 8 && (pa || pb || pp); n++) begin
            @(negedge clk);
            fm = memFillEn ? page_of(memFillAddr) : 16'h0;
            ma = pa ? banks(coreAAddr, 1'b1) : 16'h0;
            mb = pb ? banks(coreBAddr, 1'b1) : 16'h0;
            mp = pp ? banks(perAddr, 1'b0) : 16'h0;
            ea = pa && ((ma & fm) == 16'h0);
            eb = pb && ((mb & (fm | (ea ? ma : 16'h0))) == 16'h0);
            ep = pp && ((mp & (fm | (ea ? ma : 16'h0) | (eb ? mb : 16'h0))) == 16'h0);
            check(coreAGrant === ea, "grant A");
            check(coreBGrant === eb, "grant B");
            check(perGrant === ep, "grant peripheral");
            @(posedge clk);
            if (ea) coreAReq <= 1'b0;
            if (eb) coreBReq <= 1'b0;
            if (ep) perReq <= 1'b0;
            {pa, pb, pp} = {pa && !ea, pb && !eb, pp && !ep};
        end
        check(!(pa || pb || pp), "data access never granted");
        wait fork;
    endtask

    task automatic wrap_up();
        $display("Checks made: %0d, mismatches: %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (8000) @(posedge clk);
        err_total++;
        $display("MISMATCH at %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        void'($urandom(32'h6504b93c));
        {rst, fetchReq, invStart, coreAReq, coreBReq, perReq} = 6'b100000;
        {fetchAddr, invStartAddr, coreAAddr, coreBAddr, perAddr} = '0;
        cacheModeField = pcb_pkg::MODE_ENABLE;
        invWordCount   = 16'h0;
        extDelay       = 4'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        l0 = 32'h1000_0400;
        fetch(l0, missLat);
        fetch(l0, 1);
        foreach (modes[i]) begin
            @(posedge clk);
            cacheModeField <= modes[i];
            a = 32'h0000_1000 + 32'h40 * i;
            fetch(a, missLat);
            fetch(a, (modes[i] == pcb_pkg::MODE_FREEZE || modes[i] == pcb_pkg::MODE_BYPASS) ? missLat : 1);
            fetch(l0, (modes[i] == pcb_pkg::MODE_BYPASS) ? missLat : 1);
        end
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            extDelay <= 4'(3 * i);
            fetch(32'h8000_0000 | (i << 5), 3 + 3 * i);
            fetch(32'h8000_0000 | (i << 5), 1);
        end
        inval(l0 + 32'h8000, 16'h8);
        fetch(l0, 1);
        inval(l0, 16'h0);
        fetch(l0, 1);
        inval(l0 + 32'h4 * ($urandom % 8), 16'(1 + $urandom % 24));
        fetch(l0, missLat);
        repeat (40) arb_trial(pick(), 1'($urandom % 2));
        wrap_up();
    end
endmodule
